// ==== pkg/sio_defs.svh ====
// register map, function codes and reset values of the servo i/o mux
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define SIO_ADDR_W        8
`define SIO_SEL_COUNT     16
`define SIO_ADDR_SEL_LAST 8'h3c
`define SIO_ADDR_CTRL     8'h40
`define SIO_ADDR_ERR_STS  8'h44
`define SIO_ADDR_ERR_MASK 8'h48
`define SIO_ADDR_FUNC     8'h4c
`define SIO_ADDR_OUT      8'h50

// ------------------------------------------------------------
// pin counts and field layout
// ------------------------------------------------------------
`define SIO_IN_PINS       10
`define SIO_OUT_PINS      6
`define SIO_OUT_SEL_BASE  10
`define SIO_MODES         3
`define SIO_MODE_W        2
`define SIO_IN_FN_CNT     21
`define SIO_OUT_FN_CNT    16
`define SIO_NC_BIT        7
`define SIO_SEL_USED_W    24

// ------------------------------------------------------------
// function codes
// ------------------------------------------------------------
`define SIO_FN_NONE       8'h00
`define SIO_FN_SERVO_ON   5'h03
`define SIO_FN_CTRL_MODE  5'h05
`define SIO_FN_CNT_CLR    5'h07
`define SIO_FN_PULSE_INH  5'h08
`define SIO_FN_IN_MAX     5'h15
`define SIO_FN_OUT_MAX    8'h10
`define SIO_PIN_CNT_CLR   6
`define SIO_PIN_PULSE_INH 9

// ------------------------------------------------------------
// error bits, shared by sticky, mask and live fields
// ------------------------------------------------------------
`define SIO_ERR_W         6
`define SIO_ERR_DUP1      0
`define SIO_ERR_DUP2      1
`define SIO_ERR_NUM1      2
`define SIO_ERR_NUM2      3
`define SIO_ERR_CNT_CLR   4
`define SIO_ERR_PULSE_INH 5
`define SIO_CTRL_LIVE_LSB 8

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SIO_RST_SEL_IN1   32'h00000082
`define SIO_RST_SEL_IN3   32'h0000910a
`define SIO_RST_ZERO      32'h00000000

`endif

// ==== pkg/sio_pkg.sv ====
// types shared by the servo i/o function mux
package sio_pkg;

  typedef enum logic [1:0] {
    sio_mode_pos,
    sio_mode_speed,
    sio_mode_torque
  } sio_mode_t;

  typedef logic [7:0] sio_code_t;

endpackage

// ==== rtl/sio_mux.sv ====
// servo control i/o function assignment with apb register access
//
// Notes on behaviour
// - selection word: byte0 position, byte1 speed, byte2 torque, top byte zero
// - a pin whose active code selects nothing affects no function
// - same input function on two pins raises duplicate error
// - function across modes needs same pin and polarity, else duplicate error
// - mode switch function in one or two modes raises number error
// - counter clear is legal only on the seventh input pin
// - pulse inhibit is legal only on the tenth input pin
// - servo enable comes only from a pin assigned servo-on
// - input pin 1 defaults to negative over-travel, normally-closed, in position mode only
// - input pin 3 defaults to damping switch 1 and speed zero clamp
// - output codes 01h-10h pick one of sixteen status signals
// - output code 00h keeps the output transistor off
// - one output function may drive several pins without error
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sio_defs.svh"

module sio_mux
  import sio_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [9:0]  i_gen_in_closed,
  input  wire logic [15:0] i_status_fn,
  output logic      [20:0] o_in_func,
  output logic             o_servo_enable,
  output logic      [5:0]  o_gen_out_on,
  output logic             o_irq
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]             sel_r [0:`SIO_SEL_COUNT-1];
  logic [`SIO_MODE_W-1:0]  mode_r;
  logic [`SIO_ERR_W-1:0]   err_sts_r;
  logic [`SIO_ERR_W-1:0]   err_sts_nxt;
  logic [`SIO_ERR_W-1:0]   err_mask_r;
  logic [`SIO_ERR_W-1:0]   err_prev_r;
  logic [`SIO_ERR_W-1:0]   err_now;
  logic                    ack_r;
  logic [31:0]             prdata_r;
  logic                    irq_r;
  logic [9:0]              pin_s1_r;
  logic [9:0]              pin_s2_r;
  logic [20:0]             in_func_r;
  logic [20:0]             in_func_nxt;
  logic [5:0]              out_on_r;
  logic [5:0]              out_on_nxt;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // one wait state so read data comes from a flop
  wire        acc_first = i_psel & i_penable & ~ack_r;
  wire        commit    = i_psel & i_penable & ack_r;
  wire [5:0]  widx      = i_paddr[7:2];
  wire        hit_sel   = (i_paddr <= `SIO_ADDR_SEL_LAST);
  wire        hit_ctrl  = (i_paddr == `SIO_ADDR_CTRL);
  wire        hit_sts   = (i_paddr == `SIO_ADDR_ERR_STS);
  wire        hit_mask  = (i_paddr == `SIO_ADDR_ERR_MASK);
  wire        hit_func  = (i_paddr == `SIO_ADDR_FUNC);
  wire        hit_out   = (i_paddr == `SIO_ADDR_OUT);
  wire        aligned   = (i_paddr[1:0] == 2'b00);
  wire        mapped    = aligned & (hit_sel | hit_ctrl | hit_sts |
                                     hit_mask | hit_func | hit_out);
  wire        wr_ok     = commit & i_pwrite & mapped;
  wire        sts_rd    = commit & ~i_pwrite & mapped & hit_sts;

  assign o_pready  = i_penable & ack_r;
  assign o_pslverr = i_penable & ack_r & ~mapped;
  assign o_prdata  = prdata_r;

  // mode 3 is not a mode; it behaves as position control
  wire [1:0] mode_idx = (mode_r == 2'd3) ? 2'd0 : mode_r;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (!mapped) begin
      rd_val = 32'h0;
    end else if (hit_sel) begin
      rd_val = sel_r[widx[3:0]];
    end else if (hit_ctrl) begin
      rd_val[`SIO_MODE_W-1:0] = mode_r;
      rd_val[`SIO_CTRL_LIVE_LSB +: `SIO_ERR_W] = err_now;
    end else if (hit_sts) begin
      rd_val[`SIO_ERR_W-1:0] = err_sts_r;
    end else if (hit_mask) begin
      rd_val[`SIO_ERR_W-1:0] = err_mask_r;
    end else if (hit_func) begin
      rd_val[20:0] = in_func_r;
    end else begin
      rd_val[5:0] = out_on_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ack_r    <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      ack_r <= acc_first;
      if (acc_first) begin
        prdata_r <= rd_val;
      end
    end
  end

  // ------------------------------------------------------------
  // selection registers
  // ------------------------------------------------------------
  genvar gs;
  generate
    for (gs = 0; gs < `SIO_SEL_COUNT; gs = gs + 1) begin : g_sel
      localparam logic [31:0] RST =
        (gs == 0) ? `SIO_RST_SEL_IN1 :
        (gs == 2) ? `SIO_RST_SEL_IN3 : `SIO_RST_ZERO;
      always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          sel_r[gs] <= RST;
        end else if (wr_ok && hit_sel && widx[3:0] == gs) begin
          sel_r[gs] <= {8'h00, i_pwdata[`SIO_SEL_USED_W-1:0]};
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control, mask and error status
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_r     <= 2'd0;
      err_mask_r <= '0;
    end else if (wr_ok && hit_ctrl) begin
      mode_r <= i_pwdata[`SIO_MODE_W-1:0];
    end else if (wr_ok && hit_mask) begin
      err_mask_r <= i_pwdata[`SIO_ERR_W-1:0];
    end
  end

  // new errors win over a clearing read in the same cycle
  wire [`SIO_ERR_W-1:0] err_rise = err_now & ~err_prev_r;
  assign err_sts_nxt = (sts_rd ? '0 : err_sts_r) | err_rise;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      err_sts_r  <= '0;
      err_prev_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      err_sts_r  <= err_sts_nxt;
      err_prev_r <= err_now;
      irq_r      <= |(err_sts_nxt & err_mask_r);
    end
  end

  assign o_irq = irq_r;

  // ------------------------------------------------------------
  // input code table
  // ------------------------------------------------------------
  sio_code_t in_code [0:`SIO_IN_PINS-1][0:`SIO_MODES-1];

  // 01h-15h, optionally with the normally-closed bit
  function automatic logic fn_valid(input sio_code_t c);
    fn_valid = (c[6:5] == 2'b00) && (c[4:0] != 5'h00) &&
               (c[4:0] <= `SIO_FN_IN_MAX);
  endfunction

  genvar gp, gm;
  generate
    for (gp = 0; gp < `SIO_IN_PINS; gp = gp + 1) begin : g_in_pin
      for (gm = 0; gm < `SIO_MODES; gm = gm + 1) begin : g_in_mode
        assign in_code[gp][gm] = sel_r[gp][8*gm +: 8];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // assignment checks
  // ------------------------------------------------------------
  // full cross compare of every pin and mode pair; small enough
  // to stay combinational and cheap against a sequential scan
  logic                 dup_same_mode;
  logic                 dup_cross_mode;
  logic [2:0]           ctrl_mode_seen;
  logic                 cc_misplaced;
  logic                 inh_misplaced;
  logic [1:0]           ctrl_mode_cnt;

  always_comb begin
    dup_same_mode  = 1'b0;
    dup_cross_mode = 1'b0;
    ctrl_mode_seen = 3'b000;
    cc_misplaced   = 1'b0;
    inh_misplaced  = 1'b0;
    for (int p = 0; p < `SIO_IN_PINS; p++) begin
      for (int m = 0; m < `SIO_MODES; m++) begin
        if (fn_valid(in_code[p][m])) begin
          if (in_code[p][m][4:0] == `SIO_FN_CTRL_MODE) begin
            ctrl_mode_seen[m] = 1'b1;
          end
          if (in_code[p][m][4:0] == `SIO_FN_CNT_CLR &&
              p != `SIO_PIN_CNT_CLR) begin
            cc_misplaced = 1'b1;
          end
          if (in_code[p][m][4:0] == `SIO_FN_PULSE_INH &&
              p != `SIO_PIN_PULSE_INH) begin
            inh_misplaced = 1'b1;
          end
          for (int q = 0; q < `SIO_IN_PINS; q++) begin
            for (int n = 0; n < `SIO_MODES; n++) begin
              if (fn_valid(in_code[q][n]) &&
                  in_code[q][n][4:0] == in_code[p][m][4:0]) begin
                if (m == n && p != q) begin
                  dup_same_mode = 1'b1;
                end
                // other pin or polarity in another mode
                if (m != n && (p != q ||
                    in_code[q][n][`SIO_NC_BIT] !=
                    in_code[p][m][`SIO_NC_BIT])) begin
                  dup_cross_mode = 1'b1;
                end
              end
            end
          end
        end
      end
    end
  end

  // mode switch must be present in all three modes or none
  assign ctrl_mode_cnt = 2'({1'b0, ctrl_mode_seen[0]} +
                            {1'b0, ctrl_mode_seen[1]} +
                            {1'b0, ctrl_mode_seen[2]});

  always_comb begin
    err_now                      = '0;
    err_now[`SIO_ERR_DUP1]       = dup_same_mode;
    err_now[`SIO_ERR_DUP2]       = dup_cross_mode;
    err_now[`SIO_ERR_NUM1]       = (ctrl_mode_cnt == 2'd1);
    err_now[`SIO_ERR_NUM2]       = (ctrl_mode_cnt == 2'd2);
    err_now[`SIO_ERR_CNT_CLR]    = cc_misplaced;
    err_now[`SIO_ERR_PULSE_INH]  = inh_misplaced;
  end

  // ------------------------------------------------------------
  // input pins
  // ------------------------------------------------------------
  // pins are asynchronous to the control clock
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= i_gen_in_closed;
      pin_s2_r <= pin_s1_r;
    end
  end

  sio_code_t pin_act_code [0:`SIO_IN_PINS-1];
  logic [`SIO_IN_PINS-1:0] pin_used;
  logic [`SIO_IN_PINS-1:0] pin_asserted;

  genvar gi;
  generate
    for (gi = 0; gi < `SIO_IN_PINS; gi = gi + 1) begin : g_in_dec
      assign pin_act_code[gi] = in_code[gi][mode_idx];
      assign pin_used[gi] = fn_valid(pin_act_code[gi]);
      assign pin_asserted[gi] = pin_used[gi] &
        (pin_s2_r[gi] ^ pin_act_code[gi][`SIO_NC_BIT]);
    end
  endgenerate

  always_comb begin
    in_func_nxt = '0;
    for (int p = 0; p < `SIO_IN_PINS; p++) begin
      if (pin_asserted[p]) begin
        in_func_nxt[5'(pin_act_code[p][4:0] - 5'h01)] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------
  genvar go;
  generate
    for (go = 0; go < `SIO_OUT_PINS; go = go + 1) begin : g_out
      wire [7:0] oc   = sel_r[`SIO_OUT_SEL_BASE + go][8*mode_idx +: 8];
      wire [7:0] oidx = oc - 8'h01;
      // status pick, 00h or unknown keeps it off
      assign out_on_nxt[go] = (oc != `SIO_FN_NONE) &&
                              (oc <= `SIO_FN_OUT_MAX) &&
                              i_status_fn[oidx[3:0]];
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      in_func_r <= '0;
      out_on_r  <= '0;
    end else begin
      in_func_r <= in_func_nxt;
      out_on_r  <= out_on_nxt;
    end
  end

  assign o_in_func    = in_func_r;
  assign o_gen_out_on = out_on_r;
  // servo enable only through the servo-on function
  assign o_servo_enable = in_func_r[5'(`SIO_FN_SERVO_ON - 5'h01)];

endmodule
`default_nettype wire

// ==== testbench/sio_host_model.sv ====
// host controller: drives the contacts, samples the outputs
`timescale 1ns/1ps
`default_nettype none
module sio_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [9:0] i_want_closed,
  input  wire logic [5:0] i_gen_out_on,
  output logic      [9:0] o_gen_in_closed,
  output logic      [5:0] o_seen_out
);
  // contacts move just after an edge
  always @(posedge i_ref_clk) begin
    o_gen_in_closed <= i_want_closed;
    o_seen_out      <= i_gen_out_on;
  end
endmodule
`default_nettype wire

// ==== testbench/sio_mux_assertions.sv ====
// bus, pin and reset checks for the servo i/o mux
`timescale 1ns/1ps
`default_nettype none
module sio_mux_assertions (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [9:0]  i_gen_in_closed,
  input wire logic [15:0] i_status_fn,
  input wire logic [20:0] o_in_func,
  input wire logic        o_servo_enable,
  input wire logic [5:0]  o_gen_out_on,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  a_one_wait: assert property ($rose(i_penable) && i_psel |->
    !o_pready ##1 o_pready)
    else $error("ready not after exactly one wait state");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  a_ready_cause: assert property (o_pready |-> i_psel && $past(i_penable))
    else $error("ready without an access phase");
  a_err_only_ready: assert property (o_pslverr |-> o_pready)
    else $error("error response without ready");
  a_err_decode: assert property (o_pready |->
    o_pslverr == (i_paddr[1:0] != 2'b00 || i_paddr > 8'h50))
    else $error("error response does not match the address");
  a_rdata_hold: assert property (!(i_psel && i_penable) |=> $stable(o_prdata))
    else $error("read data moved outside an access");
  // ----------------------------------------
  // pins
  // ----------------------------------------
  // enable may only follow a pin edge, a setup write or a reset
  a_servo_src: assert property ($rose(o_servo_enable) |->
    $past(i_psel, 2) || $past(i_sys_rst, 4) ||
    $past(i_gen_in_closed, 3) != $past(i_gen_in_closed, 4))
    else $error("servo enable rose with no pin or setup change");
  a_out_cause: assert property (
    |o_gen_out_on |-> |$past(i_status_fn))
    else $error("output on with no status source");
  // defaults select nothing, so outputs must stay off
  a_rst_quiet: assert property (disable iff (1'b0)
    i_sys_rst |=> o_gen_out_on == 6'h00 && !o_irq)
    else $error("outputs active right after reset");
  c_refused: cover property (o_pslverr);
  c_irq: cover property ($rose(o_irq));
  c_servo: cover property ($rose(o_servo_enable));
  c_out: cover property ($rose(|o_gen_out_on));
endmodule
`default_nettype wire

// ==== testbench/test_sio_mux.sv ====
// self-checking bench for the servo i/o mux
`timescale 1ns/1ps
`default_nettype none
`include "sio_defs.svh"
module test_sio_mux;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sio_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0]  want = 10'h000;
  logic [15:0] status = 16'h0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, srv, irq, er;
  logic [9:0]  pins;
  logic [20:0] in_func;
  logic [5:0]  out_on, seen;
  int          fails = 0;
  int          checks = 0;
  // write, then expected live error field of the control word
  // defined codes only, clear functions normally-open
  sio_row_t rows [15] = '{'{8'h04, 32'h7, 32'h1000}, '{8'h04, 32'h8, 32'h2000},
    '{8'h04, 32'h5, 32'h400}, '{8'h04, 32'h505, 32'h800},
    '{8'h04, 32'h50505, 32'h0}, '{8'h04, 32'h1, 32'h0},
    '{8'h08, 32'h1, 32'h100}, '{8'h08, 32'h100, 32'h200},
    '{8'h08, 32'h0, 32'h0}, '{8'h04, 32'h8101, 32'h200},
    '{8'h04, 32'h0, 32'h0}, '{8'h18, 32'h70707, 32'h0},
    '{8'h24, 32'h80808, 32'h0}, '{8'h28, 32'h10101, 32'h0},
    '{8'h2c, 32'h10101, 32'h0}};
  always #12.5 clk = ~clk;
  sio_mux DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_gen_in_closed(pins), .i_status_fn(status), .o_in_func(in_func),
    .o_servo_enable(srv), .o_gen_out_on(out_on), .o_irq(irq));
  sio_host_model u_host (.i_ref_clk(clk), .i_want_closed(want),
    .i_gen_out_on(out_on), .o_gen_in_closed(pins), .o_seen_out(seen));
  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  // request held until the edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, rd);
  endtask
  // pins take a host edge, a sync pair and a register
  task automatic wt();
    repeat (6) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // whole run is near 600 cycles
  initial begin
    #500000;
    fails++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wt();
    chk("func", 32'h2, {11'h0, in_func});
    rdchk("funcreg", `SIO_ADDR_FUNC, 32'h2);
    want <= 10'h005;
    wt();
    chk("func", 32'h200, {11'h0, in_func});
    apb(1'b1, `SIO_ADDR_CTRL, 32'h1);
    wt();
    chk("func", 32'h0, {11'h0, in_func});
    want <= 10'h000;
    wt();
    chk("func", 32'h10000, {11'h0, in_func});
    apb(1'b1, `SIO_ADDR_CTRL, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rdchk("live", `SIO_ADDR_CTRL,
            rows[i].e);
    end
    rdchk("sticky", `SIO_ADDR_ERR_STS,
          32'h3f);
    rdchk("sticky", `SIO_ADDR_ERR_STS, 32'h0);
    apb(1'b1, `SIO_ADDR_ERR_MASK, 32'h1);
    rdchk("mask", `SIO_ADDR_ERR_MASK, 32'h1);
    apb(1'b1, 8'h08, 32'h82);
    wt();
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("sticky", `SIO_ADDR_ERR_STS, 32'h1);
    wt();
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, `SIO_ADDR_ERR_MASK, 32'h0);
    apb(1'b1, 8'h08, 32'h82);
    wt();
    chk("irq", 32'h0, {31'h0, irq});
    rdchk("sticky", `SIO_ADDR_ERR_STS, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    for (int k = 1; k <= 16; k++) begin
      apb(1'b1, 8'h30, {8'h00, k[7:0], k[7:0], k[7:0]});
      status <= 16'h0001 << (k - 1);
      wt();
      chk("out", (k == 1) ? 32'h7 : 32'h4, {26'h0, seen});
      status <= ~(16'h0001 << (k - 1));
      wt();
      chk("out", (k == 1) ? 32'h0 : 32'h3, {26'h0, seen});
    end
    rdchk("outreg", `SIO_ADDR_OUT, 32'h3);
    apb(1'b1, 8'h0c, 32'h30303);
    want <= 10'h008;
    wt();
    chk("srv", 32'h1, {31'h0, srv});
    apb(1'b1, `SIO_ADDR_CTRL, 32'h2);
    wt();
    chk("srv", 32'h1, {31'h0, srv});
    rdchk("ctrl", `SIO_ADDR_CTRL, 32'h2);
    rdchk("funcreg", `SIO_ADDR_FUNC, 32'h4);
    // mode 3 is no mode and must fall back to position control
    apb(1'b1, `SIO_ADDR_CTRL, 32'h3);
    wt();
    rdchk("ctrl", `SIO_ADDR_CTRL, 32'h3);
    rdchk("funcreg", `SIO_ADDR_FUNC, 32'h6);
    want <= 10'h000;
    wt();
    chk("srv", 32'h0, {31'h0, srv});
    apb(1'b0, 8'h54, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 8'h06, 32'h1);
    chk("misaligned", 32'h1, {31'h0, er});
    rdchk("sel2", 8'h04, 32'h0);
    apb(1'b1, 8'h04, 32'hff010101);
    rdchk("sel2", 8'h04, 32'h00010101);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk("sel1", 8'h00, 32'h82);
    rdchk("sel3", 8'h08, 32'h910a);
    rdchk("sel2", 8'h04, 32'h0);
    rdchk("ctrl", `SIO_ADDR_CTRL, 32'h0);
    results();
  end
endmodule
bind sio_mux sio_mux_assertions u_chk (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_gen_in_closed(i_gen_in_closed), .i_status_fn(i_status_fn),
  .o_in_func(o_in_func), .o_servo_enable(o_servo_enable),
  .o_gen_out_on(o_gen_out_on), .o_irq(o_irq));
`default_nettype wire
